// ===== logic/gli_pkg.sv
// constants, types and register map of the gpio / led indicator pins block
// assumes a 100 MHz core clock and an apb master with 32-bit data
package gli_pkg;

    // register byte offsets
    localparam logic [7:0]  GLI_CFG_OFS      = 8'h00;
    localparam logic [7:0]  GLI_DATA_OFS     = 8'h04;
    localparam logic [7:0]  GLI_STAT_OFS     = 8'h08;

    // configuration register fields
    localparam int          GLI_MODE_POS     = 0;
    localparam int          GLI_LEDEN_POS    = 8;
    localparam logic [5:0]  GLI_MODE_RST     = 6'h00;
    localparam logic [2:0]  GLI_LEDEN_RST    = 3'h0;

    // data register fields
    localparam int          GLI_DOUT_POS     = 0;
    localparam int          GLI_DIN_POS      = 8;
    localparam logic [2:0]  GLI_DOUT_RST     = 3'h0;

    // status register fields
    localparam int          GLI_STLED_POS    = 0;
    localparam int          GLI_STPHY_POS    = 8;

    // pin modes, two bits per pin
    localparam logic [1:0]  GLI_MODE_IN      = 2'h0;
    localparam logic [1:0]  GLI_MODE_PP      = 2'h1;
    localparam logic [1:0]  GLI_MODE_OD      = 2'h2;

    // led timing
    localparam int          GLI_CLK_HZ       = 100_000_000;
    localparam int          GLI_BLINK_MS     = 80;
    localparam int          GLI_BLINK_CYC    = GLI_BLINK_MS * (GLI_CLK_HZ / 1000);
    localparam int          GLI_CNT_W        = 23;

    // state of the activity blinker
    typedef enum logic [2:0] {
        GLI_BL_IDLE = 3'h1,
        GLI_BL_OFF  = 3'h2,
        GLI_BL_HOLD = 3'h4
    } gli_blink_st_t;

    // link status from the phy / mac
    typedef struct packed {
        logic       link_up;
        logic       autoneg_busy;
        logic       speed_100;
        logic       full_duplex;
        logic       activity;
    } gli_phy_t;

    // one group of three pins
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } gli_pin_t;

endpackage

// ===== logic/gli_blink.sv
// link and activity blinker: 80 ms off pulse, then at least 80 ms on
// assumes the activity level is synchronous to clk
module gli_blink
    import gli_pkg::*;
#(
    parameter int BLINK_CYC = GLI_BLINK_CYC
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic link_up,
    input  wire logic activity,
    output logic      led_n
);

    typedef struct packed {
        gli_blink_st_t          st;
        logic [GLI_CNT_W-1:0]   cnt;
        logic                   pend;
        logic                   led_n;
    } gli_blink_s_t;

    localparam logic [GLI_CNT_W-1:0] RELOAD = GLI_CNT_W'(BLINK_CYC - 1);

    gli_blink_s_t r_r;
    gli_blink_s_t r_nxt;

    always_comb begin
        r_nxt = r_r;
        if (!link_up) begin
            r_nxt.st    = GLI_BL_IDLE;
            r_nxt.pend  = 1'b0;
            r_nxt.led_n = 1'b1;
        end else begin
            case (r_r.st)
                GLI_BL_IDLE: begin
                    r_nxt.led_n = 1'b0;
                    if (activity) begin
                        r_nxt.st    = GLI_BL_OFF;
                        r_nxt.cnt   = RELOAD;
                        r_nxt.led_n = 1'b1;
                    end
                end
                GLI_BL_OFF: begin
                    if (r_r.cnt == '0) begin
                        r_nxt.st    = GLI_BL_HOLD;
                        r_nxt.cnt   = RELOAD;
                        r_nxt.pend  = 1'b0;
                        r_nxt.led_n = 1'b0;
                    end else begin
                        r_nxt.cnt = r_r.cnt - 1'b1;
                    end
                end
                GLI_BL_HOLD: begin
                    if (activity) begin
                        r_nxt.pend = 1'b1;
                    end
                    if (r_r.cnt == '0) begin
                        if (r_r.pend || activity) begin
                            r_nxt.st    = GLI_BL_OFF;
                            r_nxt.cnt   = RELOAD;
                            r_nxt.led_n = 1'b1;
                        end else begin
                            r_nxt.st = GLI_BL_IDLE;
                        end
                    end else begin
                        r_nxt.cnt = r_r.cnt - 1'b1;
                    end
                end
                default: begin
                    r_nxt.st    = GLI_BL_IDLE;
                    r_nxt.led_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_r <= '{st: GLI_BL_IDLE, cnt: '0, pend: 1'b0, led_n: 1'b1};
        end else if (ce) begin
            r_r <= r_nxt;
        end
    end

    assign led_n = r_r.led_n;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    off_count_a: assert property (ce && link_up && r_r.st == GLI_BL_OFF && r_r.cnt != '0 |=>
        r_r.st == GLI_BL_OFF && led_n && r_r.cnt == $past(r_r.cnt) - 1'b1)
        else $error("off pulse ended early");
    hold_min_a: assert property (ce && link_up && r_r.st == GLI_BL_HOLD && r_r.cnt != '0 |=>
        !led_n && r_r.st == GLI_BL_HOLD)
        else $error("led left on-phase before minimum time");
    act_start_a: assert property (ce && link_up && r_r.st == GLI_BL_IDLE && activity |=>
        led_n && r_r.cnt == RELOAD)
        else $error("activity did not start off pulse");
    link_on_a: assert property (ce && link_up && r_r.st == GLI_BL_IDLE && !activity |=> !led_n)
        else $error("linked idle led not lit");

endmodule

// ===== logic/gli_pins.sv
// three multiplexed gpio / status led pins with an apb register slave
// assumes phy status and pin inputs synchronous to clk, apb from the same clock
module gli_pins
    import gli_pkg::*;
#(
    parameter int BLINK_CYC = GLI_BLINK_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire gli_phy_t    phy,
    input  wire logic [2:0]  gpio_in,
    output gli_pin_t         gpio
);

    typedef struct packed {
        logic [2:0] led_en;
        logic [5:0] mode;
        logic [2:0] dout;
        logic [2:0] din;
        logic [31:0] rdata;
        gli_pin_t   pins;
    } gli_pins_s_t;

    gli_pins_s_t r_r;
    gli_pins_s_t r_nxt;
    logic        link_act_n;
    logic [2:0]  led_n;
    gli_pin_t    drv;

    // pin drive for one mode: {out, oe}
    function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic val);
        case (mode)
            GLI_MODE_PP: pin_drive = {val, 1'b1};
            GLI_MODE_OD: pin_drive = {1'b0, ~val};
            default:     pin_drive = 2'b00;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == GLI_CFG_OFS) || (a == GLI_DATA_OFS) || (a == GLI_STAT_OFS);
    endfunction

    gli_blink #(
        .BLINK_CYC (BLINK_CYC)
    ) u_blink (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .link_up   (phy.link_up),
        .activity  (phy.activity),
        .led_n     (link_act_n)
    );

    // speed, link/activity, duplex indicators
    assign led_n[0] = !(phy.link_up && phy.speed_100 && !phy.autoneg_busy);
    assign led_n[1] = link_act_n;
    assign led_n[2] = !(phy.link_up && phy.full_duplex);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            logic [1:0] gp;
            logic [1:0] ld;
            assign gp = pin_drive(r_r.mode[2*gi +: 2], r_r.dout[gi]);
            assign ld = pin_drive(GLI_MODE_OD, led_n[gi]);
            assign drv.out[gi] = r_r.led_en[gi] ? ld[1] : gp[1];
            assign drv.oe[gi]  = r_r.led_en[gi] ? ld[0] : gp[0];
        end
    endgenerate

    always_comb begin
        r_nxt      = r_r;
        r_nxt.din  = gpio_in;
        r_nxt.pins = drv;
        if (psel && !penable) begin
            r_nxt.rdata = '0;
            if (!pwrite) begin
                case (paddr)
                    GLI_CFG_OFS: begin
                        r_nxt.rdata[GLI_MODE_POS +: 6]  = r_r.mode;
                        r_nxt.rdata[GLI_LEDEN_POS +: 3] = r_r.led_en;
                    end
                    GLI_DATA_OFS: begin
                        r_nxt.rdata[GLI_DOUT_POS +: 3] = r_r.dout;
                        r_nxt.rdata[GLI_DIN_POS +: 3]  = r_r.din;
                    end
                    GLI_STAT_OFS: begin
                        r_nxt.rdata[GLI_STLED_POS +: 3] = led_n;
                        r_nxt.rdata[GLI_STPHY_POS +: 5] = phy;
                    end
                    default: r_nxt.rdata = '0;
                endcase
            end
        end
        if (psel && penable && pwrite) begin
            case (paddr)
                GLI_CFG_OFS: begin
                    r_nxt.mode   = pwdata[GLI_MODE_POS +: 6];
                    r_nxt.led_en = pwdata[GLI_LEDEN_POS +: 3];
                end
                GLI_DATA_OFS: r_nxt.dout = pwdata[GLI_DOUT_POS +: 3];
                default: r_nxt.dout = r_r.dout;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_r <= '{led_en: GLI_LEDEN_RST, mode: GLI_MODE_RST, dout: GLI_DOUT_RST,
                     din: 3'h0, rdata: 32'h0, pins: '0};
        end else if (ce) begin
            r_r <= r_nxt;
        end
    end

    assign prdata  = r_r.rdata;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped(paddr);
    assign gpio    = r_r.pins;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    led_od_a: assert property (ce && r_r.led_en[0] |=> !gpio.out[0])
        else $error("led pin driven high");
    speed_on_a: assert property (ce && r_r.led_en[0] && phy.link_up && phy.speed_100
        && !phy.autoneg_busy |=> gpio.oe[0])
        else $error("speed led not lit at 100M");
    speed_off_a: assert property (ce && r_r.led_en[0] && (!phy.link_up || !phy.speed_100
        || phy.autoneg_busy) |=> !gpio.oe[0])
        else $error("speed led lit when not at 100M");
    duplex_a: assert property (ce && r_r.led_en[2] |=> gpio.oe[2] == $past(phy.link_up && phy.full_duplex))
        else $error("duplex led wrong");
    link_pin_a: assert property (ce && r_r.led_en[1] |=> gpio.oe[1] == $past(!link_act_n))
        else $error("link led pin not following blinker");
    pp_mode_a: assert property (ce && !r_r.led_en[1] && r_r.mode[3:2] == GLI_MODE_PP |=>
        gpio.oe[1] && gpio.out[1] == $past(r_r.dout[1]))
        else $error("push-pull pin wrong");
    od_mode_a: assert property (ce && !r_r.led_en[2] && r_r.mode[5:4] == GLI_MODE_OD |=>
        !gpio.out[2] && gpio.oe[2] == $past(!r_r.dout[2]))
        else $error("open-drain pin wrong");
    in_mode_a: assert property (ce && !r_r.led_en[0] && r_r.mode[1:0] == GLI_MODE_IN |=> !gpio.oe[0])
        else $error("input pin driven");
    override_a: assert property (ce && r_r.led_en[2] && $stable(phy) ##1 ce && r_r.led_en[2]
        && $stable(phy) && $changed(r_r.dout) |=> $stable(gpio.oe[2]) && !gpio.out[2])
        else $error("gpio data leaked onto led pin");

endmodule

// ===== bench/gli_board.sv
// board side of the three pins: pull-ups and optional drivers
// assumes gpio comes straight from gli_pins
module gli_board
    import gli_pkg::*;
(
    input  wire gli_pin_t   gpio,
    input  wire logic [2:0] drv_en,
    input  wire logic [2:0] drv_val,
    output logic      [2:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pin floats up to its pull-up
    assign lvl = (gpio.oe & gpio.out) | (~gpio.oe & ((drv_en & drv_val) | ~drv_en));
endmodule

// ===== bench/testbench.sv
// self-checking bench of the gpio / led pins block
// assumes gli_pins and gli_board, apb at 100 MHz
module testbench;
    import gli_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    gli_phy_t    phy;
    logic [2:0]  lvl;
    logic [2:0]  drv_en;
    logic [2:0]  drv_val;
    gli_pin_t    gpio;
    logic [31:0] rd;
    logic        er;
    int          failures;
    int          n_checks;

    gli_pins #(.BLINK_CYC(8)) gli_pins_i (.clk(clk), .arst_n(arst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phy(phy), .gpio_in(lvl), .gpio(gpio));
    gli_board gli_board_i (.gpio(gpio), .drv_en(drv_en), .drv_val(drv_val), .lvl(lvl));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    task automatic t_regs();
        apb(1'b0, GLI_CFG_OFS, 32'h0);
        chk(rd, 32'h0, "cfg reset");
        chk({26'h0, gpio}, 32'h0, "pins after reset");
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        chk({31'h0, er}, 32'h1, "unmapped error");
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("test regs done");
    endtask

    task automatic t_modes();
        logic [5:0] md [4] = '{6'h15, 6'h2a, 6'h24, 6'h3f};
        logic [2:0] dt [4] = '{3'h5, 3'h5, 3'h3, 3'h7};
        logic [5:0] ex [4] = '{6'h2f, 6'h02, 6'h16, 6'h00};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, GLI_DATA_OFS, {29'h0, dt[i]});
            apb(1'b1, GLI_CFG_OFS, {26'h0, md[i]});
            settle();
            chk({26'h0, gpio}, {26'h0, ex[i]}, "pin mode");
        end
        @(posedge clk);
        drv_en  <= 3'h7;
        drv_val <= 3'h6;
        settle();
        apb(1'b0, GLI_DATA_OFS, 32'h0);
        chk(rd, 32'h0000_0607, "input read");
        drv_en  <= 3'h0;
        $display("test modes done");
    endtask

    task automatic t_leds();
        logic [4:0] ph [5] = '{5'h16, 5'h1e, 5'h12, 5'h14, 5'h06};
        logic [2:0] oe [5] = '{3'h7, 3'h6, 3'h6, 3'h3, 3'h0};
        apb(1'b1, GLI_DATA_OFS, 32'h7);
        apb(1'b1, GLI_CFG_OFS, 32'h0715);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            phy <= ph[i];
            settle();
            chk({26'h0, gpio}, {29'h0, oe[i]}, "led drive");
        end
        @(posedge clk);
        phy <= 5'h16;
        settle();
        apb(1'b1, GLI_DATA_OFS, 32'h0);
        settle();
        chk({26'h0, gpio}, 32'h7, "led ignores dout");
        apb(1'b0, GLI_STAT_OFS, 32'h0);
        chk(rd, 32'h0000_1600, "status read");
        $display("test leds done");
    endtask

    task automatic cnt(input logic v, output int n);
        n = 0;
        while (gpio.oe[1] === v && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_blink();
        int n;
        @(posedge clk);
        phy <= 5'h10;
        settle();
        chk({31'h0, gpio.oe[1]}, 32'h1, "link lit");
        @(posedge clk);
        phy <= 5'h11;
        cnt(1'b1, n);
        cnt(1'b0, n);
        chk(n, 8, "off pulse");
        cnt(1'b1, n);
        chk(n, 8, "on gap");
        cnt(1'b0, n);
        chk(n, 8, "repeat pulse");
        @(posedge clk);
        phy <= 5'h10;
        cnt(1'b1, n);
        chk(n, 8, "gap before pending pulse");
        cnt(1'b0, n);
        chk(n, 8, "pending pulse");
        cnt(1'b1, n);
        chk(n, 40, "idle lit");
        $display("test blink done");
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin
        failures = 0;
        n_checks = 0;
        arst_n   = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0;
        phy      = '0;
        drv_en   = 3'h0;
        drv_val  = 3'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_modes();
        t_leds();
        t_blink();
        wrap_up();
    end
endmodule
